/* File: design/supervisor_pkg.sv */
// package: register map, fields and timing of the supply supervisor block
package supervisor_pkg;
  localparam int          CLK_MHZ          = 20;
  localparam int          FAST_MASK_NS     = 2000;
  localparam int          NORMAL_MASK_NS   = 150000;
  localparam int          FAST_MASK_CYCLES = (FAST_MASK_NS * CLK_MHZ) / 1000;
  localparam int          NORMAL_MASK_CYCLES =
    (NORMAL_MASK_NS * CLK_MHZ) / 1000;
  localparam int          TIMER_WIDTH      = 12;

  localparam logic [11:0] ADDR_HIGH_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_LOW_CTRL    = 12'h004;
  localparam logic [11:0] ADDR_STATUS      = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h00C;
  localparam logic [11:0] ADDR_STATE       = 12'h010;

  // control register fields, same layout for both sides
  localparam int          CTRL_ENABLE      = 0;
  localparam int          CTRL_FAST        = 1;
  localparam int          CTRL_RESET_EN    = 2;
  localparam int          CTRL_KEEP        = 3;
  localparam logic [3:0]  CTRL_RESET_VALUE = 4'h1;

  // status and mask fields: bit 0 high side, bit 1 low side
  localparam int          SIDE_HIGH        = 0;
  localparam int          SIDE_LOW         = 1;

  typedef struct packed {
    logic keep;
    logic reset_en;
    logic fast;
    logic enable;
  } side_ctrl_type;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;
endpackage

/* File: design/supply_supervisor_event_logic.sv */
// supply supervisor event, masking, reset and pin tri-state logic
//
// Summary of operation
// R1: full-performance enable masks events for 2 us
// R2: mask time chosen by side's performance bit
// R3: normal mode masks events for 150 us
// R4: event sets flag, reset if enabled
// R5: pins tri-stated while a flag is set
// R6: keep bit 0 turns comparator off asleep
// R7: keep bit 1 keeps comparator on asleep
// R8: software enables normal mode, then fast mode; the code takes enable and fast in one write and masks for 2 us
// R9: soft clear re-enables supervisors, no mask
// R10: disabled before soft clear blocks flags after
// R11: control write after soft clear restores flags
// R12: both sides fully independent of each other
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module supply_supervisor_event_logic
  import supervisor_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      soft_power_up_clear_in,
  input  wire supervisor_pkg::apb_req_type apb_req_in,
  output supervisor_pkg::apb_rsp_type      apb_rsp_out,
  input  wire logic [1:0]                comparator_trip_in,
  input  wire logic                      deep_sleep_modes_in,
  output logic [1:0]                     comparator_on_out,
  output logic                           power_on_reset_out,
  output logic                           gpio_tristate_out,
  output logic                           irq_out
);
  import supervisor_pkg::*;

  side_ctrl_type            ctrl [2];
  side_ctrl_type            next_ctrl [2];
  logic [TIMER_WIDTH-1:0]   mask_timer [2];
  logic [TIMER_WIDTH-1:0]   next_mask_timer [2];
  logic [1:0]               comp_on_q;
  logic [1:0]               next_comp_on;
  logic [1:0]               flag_block;
  logic [1:0]               next_flag_block;
  logic [1:0]               supervisor_event_flag;
  logic [1:0]               next_event_flag;
  logic [1:0]               irq_mask;
  logic [1:0]               next_irq_mask;
  logic                     por_q;
  logic                     next_por;
  apb_rsp_type              rsp_q;
  apb_rsp_type              next_rsp;
  logic                     wr_fire;
  logic                     rd_fire;
  logic [1:0]               comp_on;
  logic [1:0]               event_seen;

  assign wr_fire = apb_req_in.psel && apb_req_in.penable &&
                   apb_req_in.pwrite;
  assign rd_fire = apb_req_in.psel && !apb_req_in.penable &&
                   !apb_req_in.pwrite;

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      // comparator runs when enabled, unless asleep without keep [R6] [R7]
      comp_on[s] = ctrl[s].enable && (!deep_sleep_modes_in || ctrl[s].keep);
      // event only once the settling mask has run out [R12]
      event_seen[s] = comp_on[s] && comp_on_q[s] && (mask_timer[s] == '0)
                      && comparator_trip_in[s];
    end
  end

  // control, timers and flag blocking per side
  always_comb begin
    logic [11:0] addr;
    addr = '0;
    next_por = 1'b0;
    for (int s = 0; s < 2; s++) begin
      addr = (s == SIDE_HIGH) ? ADDR_HIGH_CTRL : ADDR_LOW_CTRL;
      next_ctrl[s] = ctrl[s];
      next_flag_block[s] = flag_block[s];
      next_comp_on[s] = comp_on[s];
      next_mask_timer[s] = mask_timer[s];
      if (soft_power_up_clear_in) begin
        // supervisor comes back on with no settling mask [R9]
        if (!ctrl[s].enable)
          next_flag_block[s] = 1'b1; // [R10]
        next_ctrl[s].enable = 1'b1; // [R9]
        next_comp_on[s] = 1'b1;
        next_mask_timer[s] = '0; // [R9]
      end else begin
        if (wr_fire && apb_req_in.paddr == addr) begin
          next_ctrl[s] = side_ctrl_type'(apb_req_in.pwdata[3:0]);
          next_flag_block[s] = 1'b0; // [R11]
        end
        if (comp_on[s] && !comp_on_q[s]) begin
          // turn-on starts the settling mask, its length from the mode [R2]
          next_mask_timer[s] = ctrl[s].fast ?
            TIMER_WIDTH'(FAST_MASK_CYCLES) : // [R1]
            TIMER_WIDTH'(NORMAL_MASK_CYCLES); // [R3]
        end else if (!comp_on[s]) begin
          next_mask_timer[s] = '0;
        end else if (mask_timer[s] != '0) begin
          next_mask_timer[s] = mask_timer[s] - 1'b1;
        end
        if (event_seen[s] && ctrl[s].reset_en)
          next_por = 1'b1; // [R4]
      end
    end
  end

  // sticky flags: hardware set wins over write-one-to-clear
  always_comb begin
    next_event_flag = supervisor_event_flag;
    next_irq_mask = irq_mask;
    if (wr_fire && apb_req_in.paddr == ADDR_STATUS)
      next_event_flag = supervisor_event_flag & ~apb_req_in.pwdata[1:0];
    if (wr_fire && apb_req_in.paddr == ADDR_IRQ_MASK)
      next_irq_mask = apb_req_in.pwdata[1:0];
    for (int s = 0; s < 2; s++)
      if (event_seen[s] && !flag_block[s])
        next_event_flag[s] = 1'b1; // [R4] [R10]
  end

  // read data registered in the setup cycle, so the access phase is zero-wait
  always_comb begin
    next_rsp = '0;
    next_rsp.pready = 1'b1;
    if (rd_fire) begin
      unique case (apb_req_in.paddr)
        ADDR_HIGH_CTRL: next_rsp.prdata = {28'h0, ctrl[SIDE_HIGH]};
        ADDR_LOW_CTRL:  next_rsp.prdata = {28'h0, ctrl[SIDE_LOW]};
        ADDR_STATUS:    next_rsp.prdata = {30'h0, supervisor_event_flag};
        ADDR_IRQ_MASK:  next_rsp.prdata = {30'h0, irq_mask};
        ADDR_STATE:     next_rsp.prdata = {26'h0, flag_block, 2'h0,
                                           comp_on_q};
        default:        next_rsp.pslverr = 1'b1;
      endcase
    end else if (apb_req_in.psel && !apb_req_in.penable) begin
      unique case (apb_req_in.paddr)
        ADDR_HIGH_CTRL, ADDR_LOW_CTRL, ADDR_STATUS, ADDR_IRQ_MASK,
        ADDR_STATE: next_rsp.pslverr = 1'b0;
        default:    next_rsp.pslverr = 1'b1;
      endcase
    end else begin
      next_rsp = rsp_q;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int s = 0; s < 2; s++) begin
        ctrl[s] <= side_ctrl_type'(CTRL_RESET_VALUE);
        mask_timer[s] <= '0;
      end
      comp_on_q <= 2'h3;
      flag_block <= 2'h0;
      supervisor_event_flag <= 2'h0;
      irq_mask <= 2'h0;
      por_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        ctrl[s] <= next_ctrl[s];
        mask_timer[s] <= next_mask_timer[s];
      end
      comp_on_q <= next_comp_on;
      flag_block <= next_flag_block;
      supervisor_event_flag <= next_event_flag;
      irq_mask <= next_irq_mask;
      por_q <= next_por;
      rsp_q <= next_rsp;
    end
  end

  always_comb begin
    apb_rsp_out = rsp_q;
    apb_rsp_out.pready = 1'b1;
    if (!(apb_req_in.psel && apb_req_in.penable))
      apb_rsp_out.pslverr = 1'b0;
  end
  assign comparator_on_out = comp_on_q;
  assign power_on_reset_out = por_q;
  // pins float while any flag is up, until software clears it [R5]
  assign gpio_tristate_out = |supervisor_event_flag;
  assign irq_out = |(supervisor_event_flag & irq_mask);

  sequence s_fast_turn_on(int s);
    comp_on[s] && !comp_on_q[s] && ctrl[s].fast && !soft_power_up_clear_in;
  endsequence

  a_fast_mask_len: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) s_fast_turn_on(0) |=> mask_timer[0] ==
    TIMER_WIDTH'(FAST_MASK_CYCLES)) // [R1]
    else $error("fast mask length wrong");
  a_normal_mask_len: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) (comp_on[1] && !comp_on_q[1] && !ctrl[1].fast &&
    !soft_power_up_clear_in) |=> mask_timer[1] ==
    TIMER_WIDTH'(NORMAL_MASK_CYCLES)) // [R3]
    else $error("normal mask length wrong");
  a_mask_blocks_flag: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) (mask_timer[0] != '0 && !supervisor_event_flag[0])
    |=> !supervisor_event_flag[0] || mask_timer[0] == '0 ||
    $past(mask_timer[0]) == '0) // [R2]
    else $error("event flagged during mask");
  a_flag_sets: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) (event_seen[0] && !flag_block[0])
    |=> supervisor_event_flag[0]) // [R4]
    else $error("event flag not set");
  a_por_follows: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) (event_seen[1] && ctrl[1].reset_en &&
    !soft_power_up_clear_in) |=> power_on_reset_out) // [R4]
    else $error("reset not raised");
  a_tristate_flag: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) $rose(supervisor_event_flag[1]) |-> gpio_tristate_out)
    // [R5]
    else $error("pins not floated");
  a_sleep_off: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) (deep_sleep_modes_in && !ctrl[0].keep &&
    !soft_power_up_clear_in) |=> !comparator_on_out[0]) // [R6]
    else $error("comparator left on asleep");
  a_sleep_keep: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) (ctrl[1].enable && ctrl[1].keep && !wr_fire)
    |=> comparator_on_out[1]) // [R7]
    else $error("comparator dropped asleep");
  a_clear_no_mask: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) soft_power_up_clear_in |=> ctrl[0].enable &&
    ctrl[1].enable && mask_timer[0] == '0) // [R9]
    else $error("soft clear mishandled");
  a_block_after_clear: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) (soft_power_up_clear_in && !ctrl[1].enable)
    |=> flag_block[1]) // [R10]
    else $error("flags not blocked");
  a_write_unblocks: assert property (@(posedge clk_in) disable iff
    (!reset_n_in) (wr_fire && apb_req_in.paddr == ADDR_LOW_CTRL &&
    !soft_power_up_clear_in) |=> !flag_block[1]) // [R11]
    else $error("write did not unblock");

  // mask bookkeeping: turn-on loads, count down, held at zero while off
  sequence s_wake(int s);
    comp_on[s] && !comp_on_q[s] && !soft_power_up_clear_in;
  endsequence

  a_low_fast_len: assert property ( // [R1] [R12]
    @(posedge clk_in) disable iff (!reset_n_in)
    s_wake(1) ##0 ctrl[1].fast |=> mask_timer[1] ==
    TIMER_WIDTH'(FAST_MASK_CYCLES)) else $error("low fast mask wrong");
  a_high_normal_len: assert property ( // [R3]
    @(posedge clk_in) disable iff (!reset_n_in)
    s_wake(0) ##0 !ctrl[0].fast |=> mask_timer[0] ==
    TIMER_WIDTH'(NORMAL_MASK_CYCLES)) else $error("high normal mask wrong");
  a_wake_starts: assert property ( // [R2] [R6]
    @(posedge clk_in) disable iff (!reset_n_in)
    s_wake(0) |=> mask_timer[0] != '0)
    else $error("wake left no mask");
  a_mask_counts: assert property ( // [R2]
    @(posedge clk_in) disable iff (!reset_n_in)
    (mask_timer[0] != '0 && comp_on[0] && comp_on_q[0] &&
    !soft_power_up_clear_in) |=> mask_timer[0] == $past(mask_timer[0]) -
    TIMER_WIDTH'(1)) else $error("mask did not count down");
  a_off_no_mask: assert property ( // [R6]
    @(posedge clk_in) disable iff (!reset_n_in)
    (!comp_on[1] && !soft_power_up_clear_in) |=> mask_timer[1] == '0)
    else $error("mask kept while off");

  // flags, reset and pins
  a_low_flag_sets: assert property ( // [R4] [R12]
    @(posedge clk_in) disable iff (!reset_n_in)
    (event_seen[1] && !flag_block[1]) |=> supervisor_event_flag[1])
    else $error("low event flag not set");
  a_high_por: assert property ( // [R4]
    @(posedge clk_in) disable iff (!reset_n_in)
    (event_seen[0] && ctrl[0].reset_en && !soft_power_up_clear_in)
    |=> power_on_reset_out) else $error("high reset not raised");
  a_no_por_masked: assert property ( // [R1] [R3]
    @(posedge clk_in) disable iff (!reset_n_in)
    (mask_timer[0] != '0 && mask_timer[1] != '0) |=> !power_on_reset_out)
    else $error("reset raised during mask");
  a_flag_sticky: assert property ( // [R4] [R5]
    @(posedge clk_in) disable iff (!reset_n_in)
    (supervisor_event_flag[0] && !(wr_fire && apb_req_in.paddr ==
    ADDR_STATUS && apb_req_in.pwdata[0])) |=> supervisor_event_flag[0])
    else $error("flag dropped without clear");

  // sleep handling and soft clear
  a_low_sleep_off: assert property ( // [R6] [R12]
    @(posedge clk_in) disable iff (!reset_n_in)
    (deep_sleep_modes_in && !ctrl[1].keep && !soft_power_up_clear_in)
    |=> !comparator_on_out[1]) else $error("low comparator on asleep");
  a_high_keep: assert property ( // [R7]
    @(posedge clk_in) disable iff (!reset_n_in)
    (ctrl[0].enable && ctrl[0].keep && !wr_fire) |=> comparator_on_out[0])
    else $error("high comparator dropped asleep");
  a_clear_both_on: assert property ( // [R9]
    @(posedge clk_in) disable iff (!reset_n_in)
    soft_power_up_clear_in |=> comparator_on_out == 2'h3 &&
    mask_timer[1] == '0) else $error("soft clear left side off");
  a_block_high: assert property ( // [R10]
    @(posedge clk_in) disable iff (!reset_n_in)
    (soft_power_up_clear_in && !ctrl[0].enable) |=> flag_block[0])
    else $error("high flags not blocked");
  a_blocked_no_flag: assert property ( // [R10]
    @(posedge clk_in) disable iff (!reset_n_in)
    (flag_block[1] && !supervisor_event_flag[1])
    |=> !supervisor_event_flag[1]) else $error("blocked flag was set");
  a_high_write_unblocks: assert property ( // [R11]
    @(posedge clk_in) disable iff (!reset_n_in)
    (wr_fire && apb_req_in.paddr == ADDR_HIGH_CTRL &&
    !soft_power_up_clear_in) |=> !flag_block[0])
    else $error("high write did not unblock");
endmodule

/* File: verif/supply_supervisor_event_logic_test.sv */
// self-checking testbench for the supply supervisor event logic
`timescale 1ns/1ns
module supply_supervisor_event_logic_test;
  import supervisor_pkg::*;
  typedef struct {
    int         side;
    logic       fast;
    logic       rst_en;
    logic [1:0] irq_mask;
  } row_type;
  logic        clk_in, reset_n_in, soft_clear, sleep, slverr;
  logic [1:0]  trip;
  logic [31:0] rdata;
  logic [11:0] ctrl_addr;
  apb_req_type req;
  apb_rsp_type rsp;
  wire logic [1:0] comp_on;
  wire logic   por, tristate, irq;
  int          err_total, comparisons, cycles, mask_len;
  int          por_count, por_base;
  row_type     rows [4] = '{'{0, 1, 1, 2'h1}, '{0, 0, 0, 2'h0},
                            '{1, 1, 0, 2'h2}, '{1, 0, 1, 2'h0}};
  supply_supervisor_event_logic u_supply_supervisor_event_logic (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .soft_power_up_clear_in(soft_clear), .apb_req_in(req),
    .apb_rsp_out(rsp), .comparator_trip_in(trip),
    .deep_sleep_modes_in(sleep), .comparator_on_out(comp_on),
    .power_on_reset_out(por), .gpio_tristate_out(tristate),
    .irq_out(irq));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang anywhere ends the run here
  always @(posedge clk_in) begin
    cycles++;
    if (power_on_reset_out_seen()) por_count++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  function automatic logic power_on_reset_out_seen();
    return por === 1'b1;
  endfunction
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    req.paddr   <= a;
    req.pwrite  <= w;
    req.pwdata  <= d;
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    @(posedge clk_in);
    req.penable <= 1'b1;
    do @(posedge clk_in); while (rsp.pready !== 1'b1);
    rdata  = rsp.prdata;
    slverr = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    // idle cycle so the next call never re-drives psel in this time step
    @(posedge clk_in);
  endtask
  initial begin
    req = '0;
    reset_n_in = 1'b0;
    soft_clear = 1'b0;
    sleep = 1'b0;
    trip = 2'b00;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    check("comparators on", 2'b11, comp_on);
    apb(ADDR_HIGH_CTRL, 1'b0, 32'h0);
    check("high ctrl reset", 32'h1, rdata);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    check("status reset", 32'h0, rdata);
    apb(12'h100, 1'b0, 32'h0);
    check("unmapped error", 1'b1, slverr);
    check("unmapped data", 32'h0, rdata);
    foreach (rows[i]) begin
      ctrl_addr = rows[i].side ? ADDR_LOW_CTRL : ADDR_HIGH_CTRL;
      mask_len = rows[i].fast ? FAST_MASK_CYCLES : NORMAL_MASK_CYCLES;
      apb(ADDR_IRQ_MASK, 1'b1, {30'h0, rows[i].irq_mask});
      apb(ctrl_addr, 1'b1, 32'h0);
      por_base = por_count;
      apb(ctrl_addr, 1'b1, {29'h0, rows[i].rst_en, rows[i].fast, 1'b1});
      trip[rows[i].side] <= 1'b1;
      repeat (mask_len - 6) @(posedge clk_in);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      check("flag masked", 32'h0, rdata);
      check("no early reset", 1'b0, por_count != por_base);
      repeat (12) @(posedge clk_in);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      check("flag set", 32'h1 << rows[i].side, rdata);
      check("reset raised", rows[i].rst_en, por_count != por_base);
      check("pins tristate", 1'b1, tristate);
      check("irq level", rows[i].irq_mask[rows[i].side], irq);
      trip <= 2'b00;
      apb(ADDR_STATUS, 1'b1, 32'h3);
      @(posedge clk_in);
      check("pins released", 1'b0, tristate);
      check("irq cleared", 1'b0, irq);
    end
    apb(ADDR_HIGH_CTRL, 1'b1, 32'h1);
    apb(ADDR_LOW_CTRL, 1'b1, 32'h9);
    repeat (3100) @(posedge clk_in);
    sleep <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("asleep comparators", 2'b10, comp_on);
    sleep <= 1'b0;
    repeat (3) @(posedge clk_in);
    check("awake comparators", 2'b11, comp_on);
    apb(ADDR_HIGH_CTRL, 1'b1, 32'h0);
    repeat (2) @(posedge clk_in);
    check("high disabled", 2'b10, comp_on);
    soft_clear <= 1'b1;
    @(posedge clk_in);
    soft_clear <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("soft clear enables", 2'b11, comp_on);
    trip <= 2'b11;
    repeat (6) @(posedge clk_in);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    check("flags after clear", 32'h2, rdata);
    trip <= 2'b00;
    apb(ADDR_STATUS, 1'b1, 32'h3);
    apb(ADDR_HIGH_CTRL, 1'b1, 32'h1);
    trip <= 2'b01;
    repeat (3100) @(posedge clk_in);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    check("flag restored", 32'h1, rdata);
    give_verdict();
  end
endmodule
